/* File: design/bwps_bank.sv */
// Bandwidth portion bitmap and proportional stride settings bank.
`timescale 1ns/1ps
`include "bwps_defs.svh"
module bwps_bank #(
	parameter bit BW_PARTITION_PRESENT = 1'b1,
	parameter bit PORTION_MAP_PRESENT      = 1'b1,
	parameter bit STRIDE_PRESENT     = 1'b1,
	parameter bit INSTANCE_SELECT_PRESENT      = 1'b0,
	parameter bit HAS_NRW      = 1'b0,
	parameter int NUM_RIS      = 1,
	parameter int NUM_PART     = 16,
	parameter int PBM_WD       = 64,
	parameter int ALLOCATION_FIELD_WIDTH       = 16
) (
	// Clock and reset.
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	// Feature page access.
	input  wire logic        acc_valid_in,
	input  wire logic        acc_write_in,
	input  wire logic        acc_ns_in,
	input  wire logic [15:0] acc_addr_in,
	input  wire logic [31:0] acc_wdata_in,
	// Read answer.
	output logic             acc_rvalid_out,
	output logic      [31:0] acc_rdata_out,
	// Regulator lookup.
	input  wire logic        qry_valid_in,
	input  wire logic        qry_ns_in,
	input  wire logic [3:0]  qry_ris_in,
	input  wire logic [15:0] qry_part_in,
	input  wire logic [11:0] qry_portion_in,
	// Lookup answer.
	output logic             qry_valid_out,
	output logic             qry_grant_out,
	output logic             qry_stride_en_out,
	output logic      [15:0] qry_stride_cost_out
);
	localparam int NWORDS = (PBM_WD + 31) / 32;
	localparam int NSLOT  = 2 * NUM_RIS * NUM_PART;
	localparam int PDEPTH = NSLOT * NWORDS;
	localparam int PAW    = $clog2(PDEPTH);
	localparam int SAW    = $clog2(NSLOT);
	localparam bit PBM_ON  = BW_PARTITION_PRESENT & PORTION_MAP_PRESENT;
	localparam bit PROP_ON = BW_PARTITION_PRESENT & STRIDE_PRESENT;

	// Slot of one page, instance and partition in the settings memory.
	function automatic int unsigned slot_of(
		input logic ns,
		input logic [3:0] resource_instance_selector,
		input logic [15:0] part
	);
		int unsigned r;
		r = INSTANCE_SELECT_PRESENT ? int'(resource_instance_selector) : 0;
		return ((ns ? NUM_RIS : 0) + r) * NUM_PART + int'(part);
	endfunction

	// Whether instance and partition lie inside the implemented range.
	function automatic logic in_range(
		input logic [3:0] resource_instance_selector,
		input logic [15:0] part
	);
		return (int'(part) < NUM_PART) &&
			(!INSTANCE_SELECT_PRESENT || int'(resource_instance_selector) < NUM_RIS);
	endfunction

	// Implemented grant bits of bitmap word n.
	function automatic bwps_pkg::bwps_word_t word_mask(
		input int unsigned n
	);
		bwps_pkg::bwps_word_t m;
		m = `BWPS_ZERO32;
		for (int x = 0; x < 32; x++) begin
			m[x] = (n * 32 + x) < PBM_WD; // R5
		end
		return m;
	endfunction

	// Implemented bits of the stride register.
	function automatic bwps_pkg::bwps_word_t prop_mask();
		bwps_pkg::bwps_word_t m;
		m = `BWPS_ZERO32;
		m[`BWPS_PROP_EN_BIT] = 1'b1; // R12
		for (int b = 0; b <= `BWPS_COST_MSB; b++) begin
			m[b] = b < ALLOCATION_FIELD_WIDTH; // R14
		end
		return m;
	endfunction

	// Per-page selector and error status.
	logic [15:0] sel_part [2];
	logic [3:0]  sel_ris  [2];
	logic        sel_int  [2];
	logic [31:0] sel_word [2];
	logic [1:0]  esr_q    [2];

	// Access decode.
	bwps_pkg::bwps_acc_e acc_kind;
	logic [6:0]  pbm_n;
	logic [15:0] cur_part;
	logic [3:0]  cur_ris;
	logic        cur_int;
	logic        int_err;
	logic        rng_err;
	logic        cfg_ok;
	logic        word_ok;
	logic [31:0] idr_word;
	logic [31:0] direct_word;

	// Memory ports.
	logic           pbm_we;
	logic           prop_we;
	logic [PAW-1:0] pbm_acc_addr;
	logic [PAW-1:0] pbm_qry_addr;
	logic [SAW-1:0] prop_acc_addr;
	logic [SAW-1:0] prop_qry_addr;
	logic [31:0]    pbm_acc_data;
	logic [31:0]    pbm_qry_data;
	logic [31:0]    prop_acc_data;
	logic [31:0]    prop_qry_data;
	logic [6:0]     qry_word;
	logic           qry_ok;

	// Read pipeline stage.
	logic        rd_q;
	logic        rd_mem_ok_q;
	bwps_pkg::bwps_acc_e rd_kind_q;
	logic [31:0] rd_direct_q;
	logic        q_valid_q;
	logic        q_ok_q;
	logic        q_bit_ok_q;
	logic [4:0]  q_bit_q;

	generate
		for (genvar pg = 0; pg < 2; pg++) begin : g_page
			logic sel_we;
			assign sel_we = acc_valid_in && acc_write_in &&
				(acc_ns_in == 1'(pg)) &&
				(acc_kind == bwps_pkg::bwps_acc_sel);
			bwps_part_sel #(.INSTANCE_SELECT_PRESENT(INSTANCE_SELECT_PRESENT), .HAS_NRW(HAS_NRW)) u_sel (
				.mclk_in     (mclk_in),
				.srst_in     (srst_in),
				.wr_en_in    (sel_we),
				.wdata_in    (acc_wdata_in),
				.part_out    (sel_part[pg]),
				.ris_out     (sel_ris[pg]),
				.internal_out(sel_int[pg]),
				.sel_word_out(sel_word[pg])
			);
			// Error flags: a status register write clears the flags written as one and sets none; only other accesses set them.
			always_ff @(posedge mclk_in) begin
				if (srst_in) begin
					esr_q[pg] <= 2'h0;
				end else if (acc_valid_in && acc_ns_in == 1'(pg)) begin
					if (acc_write_in &&
						acc_kind == bwps_pkg::bwps_acc_esr) begin
						esr_q[pg] <= esr_q[pg] & ~acc_wdata_in[1:0];
					end else begin
						esr_q[pg][`BWPS_ESR_INT_BIT] <=
							esr_q[pg][`BWPS_ESR_INT_BIT] | int_err; // R17
						esr_q[pg][`BWPS_ESR_RANGE_BIT] <=
							esr_q[pg][`BWPS_ESR_RANGE_BIT] | rng_err;
					end
				end
			end
		end
	endgenerate

	// Decode of the feature page offset.
	always_comb begin
		acc_kind = bwps_pkg::bwps_acc_none;
		if (acc_addr_in == `BWPS_OFF_SEL) begin
			acc_kind = bwps_pkg::bwps_acc_sel;
		end else if (acc_addr_in == `BWPS_OFF_BWIDR) begin
			acc_kind = bwps_pkg::bwps_acc_idr;
		end else if (acc_addr_in == `BWPS_OFF_ESR) begin
			acc_kind = bwps_pkg::bwps_acc_esr;
		end else if (acc_addr_in == `BWPS_OFF_PROP && PROP_ON) begin
			acc_kind = bwps_pkg::bwps_acc_prop; // R6
		end else if (acc_addr_in >= `BWPS_OFF_PBM &&
			acc_addr_in <= `BWPS_OFF_PBM_LAST && PBM_ON) begin
			acc_kind = bwps_pkg::bwps_acc_pbm; // R6
		end
	end

	// Selection of the page that the access arrives on.
	always_comb begin
		cur_part = sel_part[acc_ns_in]; // R7
		cur_ris  = sel_ris[acc_ns_in];
		cur_int  = sel_int[acc_ns_in];
		pbm_n    = acc_addr_in[`BWPS_PBM_IDX_MSB:`BWPS_PBM_IDX_LSB]; // R1
		int_err  = 1'b0;
		rng_err  = 1'b0;
		if (acc_kind == bwps_pkg::bwps_acc_pbm ||
			acc_kind == bwps_pkg::bwps_acc_prop) begin
			int_err = HAS_NRW && !cur_int; // R17
			rng_err = !in_range(cur_ris, cur_part);
		end
		cfg_ok  = !int_err && !rng_err; // R9 R10
		word_ok = int'(pbm_n) < NWORDS; // R4
	end

	// Identification word and directly held registers.
	always_comb begin
		idr_word = `BWPS_ZERO32;
		idr_word[`BWPS_IDR_BWA_MSB:`BWPS_IDR_BWA_LSB] =
			6'(ALLOCATION_FIELD_WIDTH); // R14
		idr_word[`BWPS_IDR_PBM_MSB:`BWPS_IDR_PBM_LSB] =
			13'(PBM_WD); // R4
		idr_word[`BWPS_IDR_PROP_BIT] = STRIDE_PRESENT;
		idr_word[`BWPS_IDR_HPBM_BIT] = PORTION_MAP_PRESENT;
		case (acc_kind)
			bwps_pkg::bwps_acc_sel: direct_word = sel_word[acc_ns_in];
			bwps_pkg::bwps_acc_idr: direct_word = idr_word;
			bwps_pkg::bwps_acc_esr: begin
				direct_word = `BWPS_ZERO32;
				direct_word[1:0] = esr_q[acc_ns_in];
			end
			default: direct_word = `BWPS_ZERO32; // R18
		endcase
	end

	// Memory addressing for register access and for lookup.
	always_comb begin
		pbm_acc_addr = PAW'(slot_of(acc_ns_in, cur_ris, cur_part) *
			NWORDS + int'(pbm_n)); // R8
		prop_acc_addr = SAW'(slot_of(acc_ns_in, cur_ris,
			cur_part)); // R16
		qry_word = 7'(qry_portion_in >> `BWPS_WORD_SHIFT); // R2
		qry_ok = in_range(qry_ris_in, qry_part_in) &&
			int'(qry_word) < NWORDS;
		pbm_qry_addr = PAW'(slot_of(qry_ns_in, qry_ris_in, qry_part_in) *
			NWORDS + int'(qry_word));
		prop_qry_addr = SAW'(slot_of(qry_ns_in, qry_ris_in,
			qry_part_in)); // R15
		pbm_we = acc_valid_in && acc_write_in && cfg_ok && word_ok &&
			acc_kind == bwps_pkg::bwps_acc_pbm; // R11
		prop_we = acc_valid_in && acc_write_in && cfg_ok &&
			acc_kind == bwps_pkg::bwps_acc_prop; // R17
	end

	bwps_cfg_ram #(.WIDTH(32), .DEPTH(PDEPTH)) u_pbm_ram (
		.mclk_in      (mclk_in),
		.wr_en_in     (pbm_we),
		.wr_addr_in   (pbm_acc_addr),
		.wr_data_in   (acc_wdata_in & word_mask(int'(pbm_n))), // R18
		.rd_a_addr_in (pbm_acc_addr),
		.rd_a_data_out(pbm_acc_data),
		.rd_b_addr_in (pbm_qry_addr),
		.rd_b_data_out(pbm_qry_data)
	);

	bwps_cfg_ram #(.WIDTH(32), .DEPTH(NSLOT)) u_prop_ram (
		.mclk_in      (mclk_in),
		.wr_en_in     (prop_we),
		.wr_addr_in   (prop_acc_addr),
		.wr_data_in   (acc_wdata_in & prop_mask()), // R18
		.rd_a_addr_in (prop_acc_addr),
		.rd_a_data_out(prop_acc_data),
		.rd_b_addr_in (prop_qry_addr),
		.rd_b_data_out(prop_qry_data)
	);

	// First stage of a register read.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			rd_q        <= 1'b0;
			rd_mem_ok_q <= 1'b0;
			rd_kind_q   <= bwps_pkg::bwps_acc_none;
			rd_direct_q <= `BWPS_ZERO32;
		end else begin
			rd_q        <= acc_valid_in && !acc_write_in;
			rd_kind_q   <= acc_kind;
			rd_direct_q <= direct_word;
			rd_mem_ok_q <= cfg_ok && (word_ok ||
				acc_kind != bwps_pkg::bwps_acc_pbm);
		end
	end

	// Read answer, two cycles after the request.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			acc_rvalid_out <= 1'b0;
			acc_rdata_out  <= `BWPS_ZERO32;
		end else begin
			acc_rvalid_out <= rd_q;
			if (!rd_q) begin
				acc_rdata_out <= `BWPS_ZERO32;
			end else begin
				case (rd_kind_q)
					bwps_pkg::bwps_acc_pbm:
						acc_rdata_out <= rd_mem_ok_q ?
							pbm_acc_data : `BWPS_ZERO32;
					bwps_pkg::bwps_acc_prop:
						acc_rdata_out <= rd_mem_ok_q ?
							prop_acc_data : `BWPS_ZERO32;
					default: acc_rdata_out <= rd_direct_q;
				endcase
			end
		end
	end

	// First stage of a lookup.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			q_valid_q  <= 1'b0;
			q_ok_q     <= 1'b0;
			q_bit_ok_q <= 1'b0;
			q_bit_q    <= 5'h00;
		end else begin
			q_valid_q  <= qry_valid_in;
			q_ok_q     <= in_range(qry_ris_in, qry_part_in);
			q_bit_ok_q <= qry_ok && int'(qry_portion_in) < PBM_WD;
			q_bit_q    <= 5'(qry_portion_in & `BWPS_BIT_MASK); // R2
		end
	end

	// Lookup answer, two cycles after the request.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			qry_valid_out       <= 1'b0;
			qry_grant_out       <= 1'b0;
			qry_stride_en_out   <= 1'b0;
			qry_stride_cost_out <= 16'h0000;
		end else begin
			qry_valid_out <= q_valid_q;
			if (!PBM_ON) begin
				qry_grant_out <= q_ok_q;
			end else begin
				qry_grant_out <= q_bit_ok_q &&
					pbm_qry_data[q_bit_q]; // R3
			end
			qry_stride_en_out <= PROP_ON && q_ok_q &&
				prop_qry_data[`BWPS_PROP_EN_BIT]; // R12
			qry_stride_cost_out <= (PROP_ON && q_ok_q) ?
				prop_qry_data[`BWPS_COST_MSB:0] : 16'h0000; // R13
		end
	end
endmodule

/* File: design/bwps_cfg_ram.sv */
// Settings memory with one write port and two registered read ports.
`timescale 1ns/1ps
module bwps_cfg_ram #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 64,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock.
	input  wire logic             mclk_in,
	// Write port.
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// Read ports.
	input  wire logic [AW-1:0]    rd_a_addr_in,
	output logic      [WIDTH-1:0] rd_a_data_out,
	input  wire logic [AW-1:0]    rd_b_addr_in,
	output logic      [WIDTH-1:0] rd_b_data_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge mclk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		rd_a_data_out <= mem_q[rd_a_addr_in];
		rd_b_data_out <= mem_q[rd_b_addr_in];
	end
endmodule

/* File: design/bwps_part_sel.sv */
// Partition selector of one security page.
`timescale 1ns/1ps
`include "bwps_defs.svh"
module bwps_part_sel #(
	parameter bit INSTANCE_SELECT_PRESENT = 1'b0,
	parameter bit HAS_NRW = 1'b0
) (
	// Clock and reset.
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	// Register write.
	input  wire logic        wr_en_in,
	input  wire logic [31:0] wdata_in,
	// Current selection.
	output logic      [15:0] part_out,
	output logic      [3:0]  ris_out,
	output logic             internal_out,
	output logic      [31:0] sel_word_out
);
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			part_out     <= 16'h0000;
			ris_out      <= 4'h0;
			internal_out <= 1'b0;
		end else if (wr_en_in) begin
			part_out <= wdata_in[`BWPS_SEL_PART_MSB:0];
			ris_out  <= INSTANCE_SELECT_PRESENT ?
				wdata_in[`BWPS_SEL_RIS_MSB:`BWPS_SEL_RIS_LSB] : 4'h0; // R8
			internal_out <= HAS_NRW & wdata_in[`BWPS_SEL_INT_BIT]; // R10
		end
	end

	always_comb begin
		sel_word_out = `BWPS_ZERO32;
		sel_word_out[`BWPS_SEL_PART_MSB:0] = part_out;
		sel_word_out[`BWPS_SEL_INT_BIT] = internal_out;
		sel_word_out[`BWPS_SEL_RIS_MSB:`BWPS_SEL_RIS_LSB] = ris_out;
	end
endmodule

/* File: pkg/bwps_defs.svh */
// Offsets, field positions and fixed values of the bandwidth config bank.
//
// Behaviour
// R1: Bitmap words of 32 bits; word n covers portions 32n to 32n+31.
// R2: Portion p sits in word p>>5 at bit p&0x1F.
// R3: Grant bit zero forbids allocation in the portion; one permits it.
// R4: Identification register reports bitmap width; up to 128 words.
// R5: Grant bits beyond the reported width are not implemented.
// R6: Bitmap and stride exist only when their presence flags are one.
// R7: Separate secure and non-secure copies, each reached from its page.
// R8: Bitmap access uses instance and partition, or partition alone.
// R9: With narrowing, accesses use the internal index; select bit is one.
// R10: Without narrowing, accesses use the request index; select bit zero.
// R11: Software loads the selector first, then writes bitmap words.
// R12: Stride bit 31 enables proportional stride regulation.
// R13: Stride bits 15:0 hold stride minus one; larger means less share.
// R14: Implemented stride cost width equals reported allocation width.
// R15: Stride is a cost relative to other competing partitions.
// R16: Stride access uses instance and partition, or partition alone.
// R17: Access with select bit clear under narrowing flags error, no effect.
// R18: Unimplemented and reserved bits read zero and ignore writes.
`ifndef BWPS_DEFS_SVH
`define BWPS_DEFS_SVH
`define BWPS_OFF_PROP      16'h0500
`define BWPS_OFF_PBM       16'h2000
`define BWPS_OFF_PBM_LAST  16'h21FC
`define BWPS_OFF_SEL       16'h0100
`define BWPS_OFF_BWIDR     16'h0040
`define BWPS_OFF_ESR       16'h00F8
`define BWPS_PBM_IDX_MSB   8
`define BWPS_PBM_IDX_LSB   2
`define BWPS_MAX_WORDS     128
`define BWPS_WORD_SHIFT    5
`define BWPS_BIT_MASK      12'h01F
`define BWPS_PROP_EN_BIT   31
`define BWPS_COST_MSB      15
`define BWPS_SEL_PART_MSB  15
`define BWPS_SEL_INT_BIT   16
`define BWPS_SEL_RIS_LSB   24
`define BWPS_SEL_RIS_MSB   27
`define BWPS_IDR_BWA_LSB   0
`define BWPS_IDR_BWA_MSB   5
`define BWPS_IDR_PBM_LSB   16
`define BWPS_IDR_PBM_MSB   28
`define BWPS_IDR_PROP_BIT  29
`define BWPS_IDR_HPBM_BIT  30
`define BWPS_ESR_INT_BIT   0
`define BWPS_ESR_RANGE_BIT 1
`define BWPS_ZERO32        32'h0000_0000
`endif

/* File: pkg/bwps_pkg.sv */
// Types shared by the bandwidth config bank.
package bwps_pkg;
	typedef enum logic [2:0] {
		bwps_acc_none,
		bwps_acc_pbm,
		bwps_acc_prop,
		bwps_acc_sel,
		bwps_acc_idr,
		bwps_acc_esr
	} bwps_acc_e;
	typedef logic [31:0] bwps_word_t;
endpackage

/* File: tb/bwps_bank_properties.sv */
// Concurrent checks on the ports of the bandwidth config bank.
`timescale 1ns/1ps
module bwps_bank_properties #(
	parameter int NUM_PART = 16,
	parameter int PBM_WD   = 64
) (
	// Clock and reset.
	input wire logic        mclk_in,
	input wire logic        srst_in,
	// Register access.
	input wire logic        acc_valid_in,
	input wire logic        acc_write_in,
	input wire logic [15:0] acc_addr_in,
	input wire logic        acc_rvalid_out,
	input wire logic [31:0] acc_rdata_out,
	// Regulator lookup.
	input wire logic        qry_valid_in,
	input wire logic [15:0] qry_part_in,
	input wire logic [11:0] qry_portion_in,
	input wire logic        qry_valid_out,
	input wire logic        qry_grant_out,
	input wire logic        qry_stride_en_out,
	input wire logic [15:0] qry_stride_cost_out
);
	localparam int PBM_END = 32'h2000 + 4 * ((PBM_WD + 31) / 32);
	wire rd_w;
	assign rd_w = acc_valid_in && !acc_write_in;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	AST_RD_ANSWER: assert property (rd_w |-> ##2 acc_rvalid_out)
		else $error("read answer missing");
	AST_RD_CAUSE: assert property (acc_rvalid_out |-> $past(rd_w, 2))
		else $error("read answer without request");
	AST_RDATA_IDLE: assert property (!acc_rvalid_out |-> !acc_rdata_out)
		else $error("read data not zero when idle");
	AST_STRIDE_RSVD: assert property (rd_w && acc_addr_in[15:2] == 14'h0140
		|-> ##2 acc_rdata_out[30:16] == 15'h0000)
		else $error("reserved stride bits not zero");
	AST_PBM_UNIMPL: assert property (rd_w && acc_addr_in >= PBM_END[15:0]
		&& acc_addr_in <= 16'h21FF |-> ##2 acc_rdata_out == 32'h0)
		else $error("unimplemented bitmap word not zero");
	AST_QRY_ANSWER: assert property (qry_valid_in |-> ##2 qry_valid_out)
		else $error("lookup answer missing");
	AST_QRY_CAUSE: assert property (qry_valid_out
		|-> $past(qry_valid_in, 2))
		else $error("lookup answer without request");
	AST_PORTION_OOR: assert property (qry_valid_in && qry_portion_in >= PBM_WD
		|-> ##2 !qry_grant_out)
		else $error("portion beyond width granted");
	AST_PART_OOR: assert property (qry_valid_in && qry_part_in >= NUM_PART
		|-> ##2 (!qry_grant_out && !qry_stride_en_out
		&& qry_stride_cost_out == 16'h0))
		else $error("partition out of range not refused");
endmodule
bind bwps_bank bwps_bank_properties #(.NUM_PART(NUM_PART), .PBM_WD(PBM_WD))
	bwps_bank_properties_inst (.mclk_in, .srst_in, .acc_valid_in,
	.acc_write_in, .acc_addr_in, .acc_rvalid_out, .acc_rdata_out,
	.qry_valid_in, .qry_part_in, .qry_portion_in, .qry_valid_out,
	.qry_grant_out, .qry_stride_en_out, .qry_stride_cost_out);

/* File: tb/tb_top.sv */
// Self-checking bench for the bandwidth config bank.
`timescale 1ns/1ps
module tb_top;
	logic        mclk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        acc_valid_in = 1'b0;
	logic        acc_write_in = 1'b0;
	logic        acc_ns_in = 1'b0;
	logic [15:0] acc_addr_in = 16'h0000;
	logic [31:0] acc_wdata_in = 32'h0000_0000;
	logic        acc_rvalid_out;
	logic [31:0] acc_rdata_out;
	logic        qry_valid_in = 1'b0;
	logic        qry_ns_in = 1'b0;
	logic [3:0]  qry_ris_in = 4'h0;
	logic [15:0] qry_part_in = 16'h0000;
	logic [11:0] qry_portion_in = 12'h000;
	logic        qry_valid_out;
	logic        qry_grant_out;
	logic        qry_stride_en_out;
	logic [15:0] qry_stride_cost_out;
	logic [11:0] pt [6] = '{12'h000, 12'h001, 12'h03F, 12'h03E, 12'h020,
		12'h040};
	logic [5:0]  gb = 6'h05;
	int          n_mismatch = 0;
	int          checks = 0;
	always #2 mclk_in = ~mclk_in;
	bwps_bank bwps_bank_inst (.mclk_in, .srst_in, .acc_valid_in,
		.acc_write_in, .acc_ns_in, .acc_addr_in, .acc_wdata_in,
		.acc_rvalid_out, .acc_rdata_out, .qry_valid_in, .qry_ns_in,
		.qry_ris_in, .qry_part_in, .qry_portion_in, .qry_valid_out,
		.qry_grant_out, .qry_stride_en_out, .qry_stride_cost_out);
	task automatic print_verdict;
		if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic ns, input logic [15:0] a,
		input logic [31:0] d);
		@(posedge mclk_in);
		acc_ns_in    <= ns;
		acc_addr_in  <= a;
		acc_wdata_in <= d;
		acc_write_in <= w;
		acc_valid_in <= 1'b1;
		@(posedge mclk_in);
		acc_valid_in <= 1'b0;
	endtask
	task automatic wr(input logic ns, input logic [15:0] a,
		input logic [31:0] d);
		acc(1'b1, ns, a, d);
	endtask
	task automatic rd(input logic ns, input logic [15:0] a,
		input logic [31:0] e);
		acc(1'b0, ns, a, 32'h0000_0000);
		repeat (4) begin
			@(posedge mclk_in);
			#1;
			if (acc_rvalid_out === 1'b1) break;
		end
		chk({31'h0, acc_rvalid_out}, 32'h1);
		chk(acc_rdata_out, e);
	endtask
	task automatic qry(input logic ns, input logic [15:0] p,
		input logic [11:0] x, input logic [17:0] e);
		@(posedge mclk_in);
		qry_ns_in      <= ns;
		qry_part_in    <= p;
		qry_portion_in <= x;
		qry_valid_in   <= 1'b1;
		@(posedge mclk_in);
		qry_valid_in <= 1'b0;
		repeat (4) begin
			@(posedge mclk_in);
			#1;
			if (qry_valid_out === 1'b1) break;
		end
		chk({13'h0, qry_valid_out, qry_grant_out, qry_stride_en_out,
			qry_stride_cost_out}, {14'h1, e});
	endtask
	initial begin
		#4000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge mclk_in);
		srst_in <= 1'b0;
		rd(1'b0, 16'h0040, 32'h6040_0010);
		wr(1'b0, 16'h0040, 32'h0000_0000);
		rd(1'b0, 16'h0040, 32'h6040_0010);
		wr(1'b0, 16'h0100, 32'h0001_0003);
		rd(1'b0, 16'h0100, 32'h0000_0003);
		wr(1'b0, 16'h0500, 32'hFFFF_FFFF);
		rd(1'b0, 16'h0500, 32'h8000_FFFF);
		wr(1'b0, 16'h0500, 32'h8000_0007);
		rd(1'b0, 16'h0500, 32'h8000_0007);
		wr(1'b1, 16'h0100, 32'h0000_0003);
		wr(1'b1, 16'h0500, 32'h0000_0005);
		rd(1'b0, 16'h0500, 32'h8000_0007);
		rd(1'b1, 16'h0500, 32'h0000_0005);
		wr(1'b0, 16'h2000, 32'hA5A5_0001);
		wr(1'b0, 16'h2004, 32'h8000_0000);
		wr(1'b0, 16'h2008, 32'hFFFF_FFFF);
		wr(1'b1, 16'h2000, 32'h0000_0002);
		rd(1'b0, 16'h2000, 32'hA5A5_0001);
		rd(1'b0, 16'h2004, 32'h8000_0000);
		rd(1'b0, 16'h2008, 32'h0000_0000);
		rd(1'b0, 16'h21FC, 32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			qry(1'b0, 16'h0003, pt[i], {gb[i], 1'b1, 16'h0007});
		end
		qry(1'b1, 16'h0003, 12'h001, {2'b10, 16'h0005});
		wr(1'b0, 16'h0100, 32'h0000_0005);
		wr(1'b0, 16'h2000, 32'h0000_0010);
		wr(1'b0, 16'h0500, 32'h0000_0000);
		rd(1'b0, 16'h2000, 32'h0000_0010);
		qry(1'b0, 16'h0005, 12'h004, {2'b10, 16'h0000});
		qry(1'b0, 16'h0003, 12'h000, {2'b11, 16'h0007});
		wr(1'b0, 16'h0100, 32'h0000_0010);
		wr(1'b0, 16'h2000, 32'hFFFF_FFFF);
		rd(1'b0, 16'h00F8, 32'h0000_0002);
		wr(1'b0, 16'h00F8, 32'h0000_0002);
		rd(1'b0, 16'h00F8, 32'h0000_0000);
		qry(1'b0, 16'h0010, 12'h000, 18'h00000);
		wr(1'b0, 16'h0300, 32'hFFFF_FFFF);
		rd(1'b0, 16'h0300, 32'h0000_0000);
		print_verdict();
	end
endmodule
